// ### pkg/ulpi_alt_pkg.sv
/*
  Shared constants, carriers and decode for the ULPI alternate-mode
  link controller: APB register map, field layouts, reset values,
  transceiver register addresses, timing counts, resistor decode.
  Assumes a 20 MHz pclk domain and a ULPI transceiver on the far side.
*/
package ulpi_alt_pkg;

  // ---------------------------------------------------------------
  // APB register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] AD_CTRL   = 8'h00;
  localparam logic [7:0] AD_CFG    = 8'h04;
  localparam logic [7:0] AD_TX     = 8'h08;
  localparam logic [7:0] AD_STATUS = 8'h0c;
  localparam logic [7:0] AD_EVENTS = 8'h10;
  localparam logic [7:0] AD_RXCMD  = 8'h14;

  // CTRL command bits
  localparam int CMD_APPLY  = 0;
  localparam int CMD_SLEEP  = 1;
  localparam int CMD_SERIAL = 2;
  localparam int CMD_WAKE   = 3;

  // EVENTS sticky bits
  localparam int EV_RXCMD  = 0;
  localparam int EV_ABORT  = 1;
  localparam int EV_UNASK  = 2;

  // ---------------------------------------------------------------
  // Transceiver registers and fields
  // ---------------------------------------------------------------
  localparam logic [5:0] UR_FUNC_CTRL = 6'h04;
  localparam logic [5:0] UR_IFC_CTRL  = 6'h07;
  localparam logic [5:0] UR_OTG_CTRL  = 6'h0a;
  localparam logic [1:0] TXCMD_REGWR  = 2'b10;
  localparam int FC_SPEED_LSB  = 0;
  localparam int FC_TERM       = 2;
  localparam int FC_OP_LSB     = 3;
  localparam int FC_SLEEP_NOT  = 6;
  localparam int IC_THREE_WIRE = 1;
  localparam int IC_CLK_KEEP   = 3;
  localparam int OTG_PLUS_SINK = 1;
  localparam int OTG_MINUS_SINK = 2;
  localparam logic [1:0] OP_TRISTATE = 2'b01;
  localparam logic [1:0] SPEED_HS    = 2'b00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int REF_SETTLE_NS  = 2000;
  localparam int REF_SETTLE_CYC =
    (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       stop_ref;
    logic       clock_keep_on;
    logic       minus_line_sink_req;
    logic       plus_line_sink_req;
    logic [1:0] op_choice;
    logic       term_choice;
    logic [1:0] speed_choice;
  } cfg_t;

  // Power-up state: full-speed, both sinks requested
  localparam cfg_t CFG_RST = 9'h061;

  typedef struct packed {
    logic se0;
    logic serial_diff_bit;
    logic tx_enable;
  } tx_t;

  typedef struct packed {
    logic fast_term_on;
    logic minus_line_sink_on;
    logic plus_line_sink_on;
    logic plus_line_lift_on;
  } res_t;

  typedef struct packed {
    logic       dir;
    logic       nxt;
    logic [3:0] data;
  } ulpi_in_t;

  // Resistor enables the device will apply for a set of fields
  function automatic res_t decode_res(input cfg_t c);
    logic off;
    res_t r;
    off = (c.op_choice == OP_TRISTATE);
    r.plus_line_lift_on  = c.term_choice & ~c.plus_line_sink_req
                           & ~off;
    r.plus_line_sink_on  = c.plus_line_sink_req & ~off;
    r.minus_line_sink_on = c.minus_line_sink_req & ~off;
    r.fast_term_on = (c.speed_choice == SPEED_HS)
                     & ~c.term_choice & ~off;
    return r;
  endfunction

endpackage

// ### verilog/pin_sync.sv
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes the bundle members are independent levels.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 6
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } sync_st_t;

  sync_st_t s;
  sync_st_t next_s;

  if (W < 1) begin : g_chk
    $error("pin_sync width must be at least 1");
  end

  // First stage feeds only the second
  always_comb begin
    next_s.s1 = pins;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign synced = s.s2;

endmodule

// ### verilog/ulpi_alt_link.sv
/*
  Link-side controller for the alternate modes of a ULPI transceiver:
  sends register writes, enters low-power or three-wire serial mode,
  drives the serial pins, wakes the device by STP, captures the
  status byte that follows, and reports the expected resistor state.
  Assumes an APB master on pclk and transceiver pins from another
  clock domain, synchronised here before use.
*/
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps

module ulpi_alt_link #(
  parameter int unsigned SETTLE_CYCLES = ulpi_alt_pkg::REF_SETTLE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ulpi_dir,
  input  wire logic        ulpi_nxt,
  input  wire logic [3:0]  ulpi_data_in,
  output logic      [3:0]  ulpi_data_out,
  output logic      [3:0]  ulpi_data_oe_n,
  output logic             ulpi_stp,
  output logic             ref_clk_run
);

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_chk
    $error("SETTLE_CYCLES must lie in 1..255");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CMD_LO, S_CMD_HI, S_DAT_LO, S_DAT_HI, S_STOP,
    S_ENTER, S_TURN_IN, S_SLEEP, S_SERIAL, S_CLK_WAIT, S_WAKE,
    S_TURN_OUT, S_RX_TURN, S_RX
  } fsm_t;

  typedef enum logic [1:0] {T_NONE, T_SLEEP, T_SERIAL} tgt_t;

  typedef struct packed {
    fsm_t                st;
    tgt_t                after;
    logic                then_otg;
    ulpi_alt_pkg::cfg_t  cfg;
    ulpi_alt_pkg::tx_t   tx;
    logic [3:0]          req;
    logic [2:0]          ev;
    logic [7:0]          cmd;
    logic [7:0]          dat;
    logic [7:0]          cnt;
    logic [7:0]          rxcmd;
    logic                rx_half;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    logic                stp;
    logic [3:0]          dout;
    logic [3:0]          doe_n;
    logic                ref_run;
  } st_t;

  st_t                    s;
  st_t                    next_s;
  ulpi_alt_pkg::ulpi_in_t p;
  ulpi_alt_pkg::res_t     res;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  pin_sync #(
    .W ($bits(ulpi_alt_pkg::ulpi_in_t))
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    ({ulpi_dir, ulpi_nxt, ulpi_data_in}),
    .synced  (p)
  );

  // Expected device resistors from the programmed fields
  assign res = ulpi_alt_pkg::decode_res(s.cfg);

  // Function control byte built from the programmed fields
  function automatic logic [7:0] func_byte(input ulpi_alt_pkg::cfg_t c,
                                           input logic sleep_not);
    logic [7:0] b;
    b = 8'h00;
    b[ulpi_alt_pkg::FC_SPEED_LSB +: 2] = c.speed_choice;
    b[ulpi_alt_pkg::FC_TERM]           = c.term_choice;
    b[ulpi_alt_pkg::FC_OP_LSB +: 2]    = c.op_choice;
    b[ulpi_alt_pkg::FC_SLEEP_NOT]      = sleep_not;
    return b;
  endfunction

  // Register write command byte
  function automatic logic [7:0] regwr(input logic [5:0] a);
    return {ulpi_alt_pkg::TXCMD_REGWR, a};
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0]  take;
    logic [2:0]  ev_set;
    logic [31:0] rd;
    logic        hit;
    logic        wr_ok;
    logic [7:0]  otg;
    logic [7:0]  ifc;
    next_s        = s;
    take          = 4'h0;
    ev_set        = 3'h0;
    wr_ok         = 1'b0;
    rd            = 32'h0000_0000;
    hit           = 1'b1;
    otg           = 8'h00;
    ifc           = 8'h00;
    otg[ulpi_alt_pkg::OTG_PLUS_SINK]  = s.cfg.plus_line_sink_req;
    otg[ulpi_alt_pkg::OTG_MINUS_SINK] = s.cfg.minus_line_sink_req;
    ifc[ulpi_alt_pkg::IC_THREE_WIRE]  = 1'b1;
    ifc[ulpi_alt_pkg::IC_CLK_KEEP]    = s.cfg.clock_keep_on;

    // Read mux, sampled in the setup cycle
    case (paddr)
      ulpi_alt_pkg::AD_CTRL:   rd = {28'h0, s.req};
      ulpi_alt_pkg::AD_CFG:    rd = {23'h0, s.cfg};
      ulpi_alt_pkg::AD_TX:     rd = {29'h0, s.tx};
      ulpi_alt_pkg::AD_STATUS: rd = {18'h0, res, p.data, p.nxt, p.dir,
                                     s.st};
      ulpi_alt_pkg::AD_EVENTS: rd = {29'h0, s.ev};
      ulpi_alt_pkg::AD_RXCMD:  rd = {24'h0, s.rxcmd};
      default:                 hit = 1'b0;
    endcase

    // Ready goes high in the access phase: no wait states
    next_s.pready  = psel & ~penable;
    next_s.pslverr = psel & ~penable & ~hit;
    if (psel && !penable) begin
      next_s.prdata = hit ? rd : 32'h0000_0000;
    end
    wr_ok = psel & penable & s.pready & pwrite & ~s.pslverr;

    // Link state machine
    case (s.st)
      S_IDLE: begin
        next_s.stp   = 1'b0;
        next_s.dout  = 4'h0;
        next_s.doe_n = 4'h0;
        if (p.dir) begin
          next_s.doe_n = 4'hf;
          next_s.st    = S_RX_TURN;
        end else if (s.req[ulpi_alt_pkg::CMD_APPLY]) begin
          take[ulpi_alt_pkg::CMD_APPLY] = 1'b1;
          next_s.cmd      = regwr(ulpi_alt_pkg::UR_FUNC_CTRL);
          next_s.dat      = func_byte(s.cfg, 1'b1);
          next_s.then_otg = 1'b1;
          next_s.after    = T_NONE;
          next_s.st       = S_CMD_LO;
        end else if (s.req[ulpi_alt_pkg::CMD_SLEEP]) begin
          take[ulpi_alt_pkg::CMD_SLEEP] = 1'b1;
          next_s.cmd   = regwr(ulpi_alt_pkg::UR_FUNC_CTRL);
          next_s.dat   = func_byte(s.cfg, 1'b0);
          next_s.after = T_SLEEP;
          next_s.st    = S_CMD_LO;
        end else if (s.req[ulpi_alt_pkg::CMD_SERIAL]) begin
          take[ulpi_alt_pkg::CMD_SERIAL] = 1'b1;
          next_s.cmd   = regwr(ulpi_alt_pkg::UR_IFC_CTRL);
          next_s.dat   = ifc;
          next_s.after = T_SERIAL;
          next_s.st    = S_CMD_LO;
        end
      end
      S_CMD_LO, S_CMD_HI, S_DAT_LO, S_DAT_HI: begin
        // Low nibble first; command pair repeats until throttle seen
        if (p.dir) begin
          next_s.doe_n    = 4'hf;
          next_s.after    = T_NONE;
          next_s.then_otg = 1'b0;
          ev_set[ulpi_alt_pkg::EV_ABORT] = 1'b1;
          next_s.st       = S_RX_TURN;
        end else if (s.st == S_CMD_LO) begin
          next_s.dout = s.cmd[7:4];
          next_s.st   = S_CMD_HI;
        end else if (s.st == S_CMD_HI) begin
          next_s.dout = p.nxt ? s.dat[3:0] : s.cmd[3:0];
          next_s.st   = p.nxt ? S_DAT_LO : S_CMD_LO;
        end else if (s.st == S_DAT_LO) begin
          next_s.dout = s.dat[7:4];
          next_s.st   = S_DAT_HI;
        end else begin
          next_s.dout = 4'h0;
          next_s.stp  = 1'b1;
          next_s.st   = S_STOP;
        end
      end
      S_STOP: begin
        next_s.stp = 1'b0;
        if (s.then_otg) begin
          next_s.then_otg = 1'b0;
          next_s.cmd  = regwr(ulpi_alt_pkg::UR_OTG_CTRL);
          next_s.dat  = otg;
          next_s.dout = next_s.cmd[3:0];
          next_s.st   = S_CMD_LO;
        end else begin
          next_s.st = (s.after == T_NONE) ? S_IDLE : S_ENTER;
        end
      end
      S_ENTER: begin
        // Keep the bus low until the device takes it
        if (p.dir) begin
          next_s.doe_n = 4'hf;
          next_s.st    = S_TURN_IN;
        end
      end
      S_TURN_IN: begin
        if (s.after == T_SLEEP) begin
          next_s.ref_run = ~s.cfg.stop_ref;
          next_s.st      = S_SLEEP;
        end else begin
          next_s.st      = S_SERIAL;
        end
        next_s.after = T_NONE;
      end
      S_SLEEP, S_SERIAL: begin
        if (s.st == S_SERIAL) begin
          // Enable always driven; data and SE0 only while sending
          next_s.dout  = {1'b0, s.tx.se0, s.tx.serial_diff_bit,
                          s.tx.tx_enable};
          next_s.doe_n = {1'b1, ~s.tx.tx_enable, ~s.tx.tx_enable,
                          1'b0};
        end else begin
          // Pins 0..3 are line state, low, interrupt: inputs only
          next_s.doe_n = 4'hf;
        end
        if (!p.dir) begin
          ev_set[ulpi_alt_pkg::EV_UNASK] = 1'b1;
          next_s.doe_n = 4'hf;
          next_s.st    = S_TURN_OUT;
        end else if (s.req[ulpi_alt_pkg::CMD_WAKE]) begin
          take[ulpi_alt_pkg::CMD_WAKE] = 1'b1;
          next_s.ref_run = 1'b1;
          next_s.cnt     = 8'(SETTLE_CYCLES);
          next_s.doe_n   = 4'hf;
          next_s.st      = S_CLK_WAIT;
        end
      end
      S_CLK_WAIT: begin
        // Let the reference clock settle before asking to exit
        next_s.cnt = s.cnt - 8'h01;
        if (s.cnt == 8'h01) begin
          next_s.stp = 1'b1;
          next_s.st  = S_WAKE;
        end
      end
      S_WAKE: begin
        if (!p.dir) begin
          next_s.stp = 1'b0;
          next_s.st  = S_TURN_OUT;
        end
      end
      S_TURN_OUT: begin
        // Turnaround: ignore the bus one cycle, then drive low
        next_s.doe_n = 4'h0;
        next_s.dout  = 4'h0;
        next_s.st    = S_IDLE;
      end
      S_RX_TURN, S_RX: begin
        // Entry edge already saw the turnaround; nibbles start here
        next_s.st = S_RX;
        if (!p.dir) begin
          next_s.rx_half = 1'b0;  // Odd nibble dropped
          next_s.st      = S_TURN_OUT;
        end else if (!p.nxt) begin
          // Status byte, e.g. the one owed after a wake
          next_s.rx_half = ~s.rx_half;
          if (!s.rx_half) begin
            next_s.rxcmd[3:0] = p.data;
          end else begin
            next_s.rxcmd[7:4] = p.data;
            ev_set[ulpi_alt_pkg::EV_RXCMD] = 1'b1;
          end
        end
      end
      default: begin
        next_s.st = S_IDLE;
      end
    endcase

    // Register writes; hardware set wins over software clear
    next_s.req = s.req & ~take;
    next_s.ev  = s.ev | ev_set;
    if (wr_ok) begin
      case (paddr)
        ulpi_alt_pkg::AD_CTRL:   next_s.req = next_s.req | pwdata[3:0];
        ulpi_alt_pkg::AD_CFG:    next_s.cfg = pwdata[8:0];
        ulpi_alt_pkg::AD_TX:     next_s.tx  = pwdata[2:0];
        ulpi_alt_pkg::AD_EVENTS: next_s.ev  = (s.ev & ~pwdata[2:0])
                                              | ev_set;
        default:                 next_s.ev  = s.ev | ev_set;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.st       <= S_IDLE;
      s.after    <= T_NONE;
      s.cfg      <= ulpi_alt_pkg::CFG_RST;
      s.ref_run  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign prdata         = s.prdata;
  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign ulpi_data_out  = s.dout;
  assign ulpi_data_oe_n = s.doe_n;
  assign ulpi_stp       = s.stp;
  assign ref_clk_run    = s.ref_run;

endmodule

// ### tb/ulpi_alt_link_monitor.sv
/* Port checker for ulpi_alt_link, bound into every instance.
   Assumes only the top module's ports are visible. */
`timescale 1ns/10ps
module ulpi_alt_link_monitor #(
  parameter int unsigned SETTLE_CYCLES = 3
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ulpi_dir,
  input wire logic        ulpi_nxt,
  input wire logic [3:0]  ulpi_data_in,
  input wire logic [3:0]  ulpi_data_out,
  input wire logic [3:0]  ulpi_data_oe_n,
  input wire logic        ulpi_stp,
  input wire logic        ref_clk_run
);
  // ------------
  // Relations
  // ------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       mapped;
  logic       rel;
  logic [7:0] run_cnt;
  // Cycles the reference clock has run, saturating at the top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt <= 8'h00;
    end else if (!ref_clk_run) begin
      run_cnt <= 8'h00;
    end else if (run_cnt != 8'hff) begin
      run_cnt <= run_cnt + 8'h01;
    end
  end
  // Decoded once so each property stays short
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  assign rel    = (ulpi_data_oe_n == 4'hf);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready late after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held past access");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  a_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("read data not zero on slave error");
  a_stp_clock_first: assert property (
    $rose(ulpi_stp) && rel |-> ref_clk_run && $past(ref_clk_run)
    && run_cnt >= 8'(SETTLE_CYCLES))
    else $error("wake raised with reference clock stopped");
  a_stp_held: assert property (
    ulpi_stp && ulpi_dir && rel |=> ulpi_stp)
    else $error("wake dropped before bus returned");
  a_exit_turnaround: assert property ($fell(ulpi_dir) |-> rel [*3])
    else $error("bus driven without turnaround");
  // Five samples cover the two-flop input delay plus the state update
  a_int_pin_free: assert property (
    ulpi_dir && $past(ulpi_dir) && $past(ulpi_dir, 2) && $past(ulpi_dir, 3)
    && $past(ulpi_dir, 4) |-> ulpi_data_oe_n[3])
    else $error("link drives interrupt pin");
  a_tx_direction: assert property (
    ulpi_dir && ulpi_data_oe_n[3] && (ulpi_data_oe_n[2:1] != 2'b11)
    |-> !ulpi_data_oe_n[0] && ulpi_data_out[0])
    else $error("serial pins driven without transmit enable");

  c_wake: cover property ($rose(ulpi_stp) && rel);
  c_err: cover property (pslverr);
  c_exit: cover property ($fell(ulpi_dir));
endmodule

bind ulpi_alt_link ulpi_alt_link_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES))
  ulpi_alt_link_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_in(ulpi_data_in),
  .ulpi_data_out(ulpi_data_out), .ulpi_data_oe_n(ulpi_data_oe_n),
  .ulpi_stp(ulpi_stp), .ref_clk_run(ref_clk_run));

// ### tb/ulpi_dev_model.sv
/* Behavioural transceiver: register writes, low-power and serial modes,
   wake by stop, status byte. Assumes link pins in the pclk domain. */
`timescale 1ns/10ps
module ulpi_dev_model #(
  parameter logic [7:0] RXCMD_VAL = 8'h5a
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] data_out,
  input  wire logic [3:0] oe_n,
  input  wire logic       stp,
  input  wire logic       ref_clk_run,
  input  wire logic [1:0] line_state,
  input  wire logic       irq,
  input  wire logic       rx_diff,
  input  wire logic       rx_se0,
  output logic            dir,
  output logic            nxt,
  output logic      [3:0] data_in
);
  // ------------
  // Pins and state
  // ------------
  logic [15:0] hist;
  logic [7:0]  func_reg, ifc_reg, otg_reg, cmd, dat;
  logic [1:0]  mode, tx_seen;
  logic [3:0]  drv, en, last, cnt;
  logic        dir_q, clk_err, irq_seen, rx_pend, tx;
  assign tx  = !oe_n[0] & data_out[0];
  assign cmd = {hist[11:8], hist[15:12]};
  assign dat = {hist[3:0], hist[7:4]};

  // Device wins a clash; a floating pin flips each cycle, never holds
  always_comb begin
    drv = '0;
    en  = '0;
    if (mode == 2'd1 && dir_q) begin
      drv = {irq, 1'b0, line_state};
      en  = 4'hf;
    end else if (mode == 2'd2 && dir_q) begin
      drv = {irq, rx_se0, rx_diff, 1'b0};
      en  = {1'b1, ~tx, ~tx, 1'b0};
    end else if (rx_pend && cnt > 4'd5) begin
      drv = (cnt == 4'd6) ? RXCMD_VAL[3:0] : RXCMD_VAL[7:4];
      en  = 4'hf;
    end
    for (int i = 0; i < 4; i++)
      data_in[i] = en[i] ? drv[i] : !oe_n[i] ? data_out[i] : ~last[i];
  end

  // Register writes, mode entry and exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {dir, nxt, dir_q, clk_err, irq_seen, rx_pend} <= '0;
      {hist, mode, tx_seen, cnt, last, ifc_reg} <= '0;
      func_reg <= 8'h41;
      otg_reg  <= 8'h06;
    end else begin
      dir_q <= dir;
      last  <= data_in;
      if (mode == 2'd0 && !rx_pend) begin
        if (!oe_n[0] && !stp) hist <= {hist[11:0], data_out};
        nxt <= !stp && (nxt || (!oe_n[0] && data_out != 4'h0));
        if (stp && cmd[7:6] == ulpi_alt_pkg::TXCMD_REGWR) begin
          hist <= '0;
          case (cmd[5:0])
            ulpi_alt_pkg::UR_FUNC_CTRL: begin
              func_reg <= dat;
              if (!dat[ulpi_alt_pkg::FC_SLEEP_NOT]) mode <= 2'd1;
            end
            ulpi_alt_pkg::UR_IFC_CTRL: begin
              ifc_reg <= dat;
              if (dat[ulpi_alt_pkg::IC_THREE_WIRE]) mode <= 2'd2;
            end
            ulpi_alt_pkg::UR_OTG_CTRL: otg_reg <= dat;
            default: ;
          endcase
        end
      end else if (mode != 2'd0) begin
        dir      <= 1'b1;
        irq_seen <= irq_seen | irq;
        if (mode == 2'd2 && tx) tx_seen <= data_in[2:1];
        if (stp) begin
          clk_err  <= clk_err | !ref_clk_run;
          dir      <= 1'b0;
          mode     <= 2'd0;
          func_reg[ulpi_alt_pkg::FC_SLEEP_NOT] <= 1'b1;
          ifc_reg[ulpi_alt_pkg::IC_THREE_WIRE] <= 1'b0;
          rx_pend  <= irq_seen & irq;
          irq_seen <= 1'b0;
          cnt      <= '0;
        end
      end else begin
        if (!stp) cnt <= cnt + 4'd1;
        if (cnt == 4'd4) dir <= 1'b1;
        if (cnt == 4'd7) {dir, rx_pend} <= 2'b00;
      end
    end
  end
endmodule

// ### tb/ulpi_alt_link_tb_top.sv
/* Self-checking bench: APB tasks and scenarios for ulpi_alt_link.
   Assumes the package, design, checker and device model compile first. */
`timescale 1ns/10ps
module ulpi_alt_link_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, dir, nxt, stp, ref_run;
  logic        irq, rx_diff, rx_se0;
  logic [1:0]  lstate;
  logic [3:0]  din, dout, doe_n;
  logic [6:0]  cfgs [6] = '{7'h70, 7'h14, 7'h6f, 7'h45, 7'h67, 7'h00};
  int          mismatches, n_tests;

  ulpi_alt_link #(.SETTLE_CYCLES(3)) ulpi_alt_link_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ulpi_dir(dir), .ulpi_nxt(nxt), .ulpi_data_in(din),
    .ulpi_data_out(dout), .ulpi_data_oe_n(doe_n), .ulpi_stp(stp),
    .ref_clk_run(ref_run));
  ulpi_dev_model ulpi_dev_model_inst (.pclk(pclk), .presetn(presetn),
    .data_out(dout), .oe_n(doe_n), .stp(stp), .ref_clk_run(ref_run),
    .line_state(lstate), .irq(irq), .rx_diff(rx_diff), .rx_se0(rx_se0),
    .dir(dir), .nxt(nxt), .data_in(din));

  // ------------
  // Tasks
  // ------------
  // Ready, data and error taken at the rising edge that sees ready high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] v);
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, a, 0);
      if ((rd & 32'hf) === v) break;
    end
    chk("poll", v, rd & 32'hf);
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Bench view of {fast_term, minus_sink, plus_sink, plus_lift}
  function automatic logic [3:0] res_exp(input logic [6:0] c);
    logic off;
    off = (c[4:3] == 2'b01);
    return {c[1:0] == 2'b00 && !c[2] && !off, c[6] && !off, c[5] && !off,
            c[2] && !c[5] && !off};
  endfunction

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, irq, rx_diff, rx_se0} = '0;
    {lstate, mismatches, n_tests, presetn} = '0;
    lstate = 2'b10;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ulpi_alt_pkg::AD_CFG, 0);
    chk("cfg_rst", 32'h61, rd);
    apb(1'b0, 8'h20, 0);
    chk("slverr", 32'h1, 32'(err));
    chk("ref_run", 32'h1, 32'(ref_run));
    // Decode per signalling state, then push the fields to the device
    foreach (cfgs[k]) begin
      apb(1'b1, ulpi_alt_pkg::AD_CFG, 32'(cfgs[k]));
      apb(1'b0, ulpi_alt_pkg::AD_STATUS, 0);
      chk("res", 32'(res_exp(cfgs[k])), 32'(rd[13:10]));
      apb(1'b1, ulpi_alt_pkg::AD_CTRL, 32'h1);
      poll(ulpi_alt_pkg::AD_CTRL, 0);
      poll(ulpi_alt_pkg::AD_STATUS, 0);
      chk("func", 32'(cfgs[k][4:0]),
          32'(ulpi_dev_model_inst.func_reg[4:0]));
      chk("otg", 32'(cfgs[k][6:5]),
          32'(ulpi_dev_model_inst.otg_reg[2:1]));
    end
    // Low-power twice: interrupt lasting, then interrupt gone by wake
    apb(1'b1, ulpi_alt_pkg::AD_CFG, 32'h161);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ulpi_alt_pkg::AD_EVENTS, 32'h7);
      apb(1'b1, ulpi_alt_pkg::AD_CTRL, 32'h2);
      poll(ulpi_alt_pkg::AD_STATUS, 32'h8);
      irq <= 1'b1;
      repeat (2) apb(1'b0, ulpi_alt_pkg::AD_STATUS, 0);
      chk("lp_pins", 32'h29, 32'(rd[9:4]));
      chk("ref_stop", 32'h0, 32'(ref_run));
      irq <= (s == 0);
      apb(1'b1, ulpi_alt_pkg::AD_CTRL, 32'h8);
      poll(ulpi_alt_pkg::AD_STATUS, 0);
      repeat (6) apb(1'b0, ulpi_alt_pkg::AD_EVENTS, 0);
      chk("ev_rx", 32'(s == 0), rd);
      apb(1'b0, ulpi_alt_pkg::AD_RXCMD, 0);
      if (s == 0) chk("rxcmd", 32'(ulpi_dev_model_inst.RXCMD_VAL), rd);
      irq <= 1'b0;
    end
    chk("clk_order", 32'h0, 32'(ulpi_dev_model_inst.clk_err));
    // Three-wire serial: for each nonzero code, transmit it, then receive it
    apb(1'b1, ulpi_alt_pkg::AD_CFG, 32'he1);
    apb(1'b1, ulpi_alt_pkg::AD_CTRL, 32'h4);
    poll(ulpi_alt_pkg::AD_STATUS, 32'h9);
    chk("ifc", 32'ha, 32'(ulpi_dev_model_inst.ifc_reg & 8'h0a));
    for (int t = 1; t < 4; t++) begin
      apb(1'b1, ulpi_alt_pkg::AD_TX, 32'(t * 2 + 1));
      apb(1'b0, ulpi_alt_pkg::AD_STATUS, 0);
      chk("tx_seen", 32'(t), 32'(ulpi_dev_model_inst.tx_seen));
      {rx_se0, rx_diff} <= 2'(t);
      apb(1'b1, ulpi_alt_pkg::AD_TX, 0);
      repeat (2) apb(1'b0, ulpi_alt_pkg::AD_STATUS, 0);
      chk("rx_pins", 32'(t * 2), 32'(rd[9:6]));
    end
    apb(1'b1, ulpi_alt_pkg::AD_CTRL, 32'h8);
    poll(ulpi_alt_pkg::AD_STATUS, 0);
    wrap_up();
  end
endmodule
